// ### inc/rx_pattern_filter_defines.vh
// Offsets, field positions, reset values and mode codes of the receive pattern filter.
// Assumes a 32-bit APB bus with byte addresses and one word per register.
`ifndef RX_PATTERN_FILTER_DEFINES_VH
`define RX_PATTERN_FILTER_DEFINES_VH

// Register byte addresses
`define ADDR_RX_FILTER_CONTROL   8'h00
`define ADDR_MAC_CONTROL_ONE     8'h04
`define ADDR_WINDOW_OFFSET       8'h08
`define ADDR_WINDOW_MASK_LO      8'h0c
`define ADDR_WINDOW_MASK_HI      8'h10
`define ADDR_EXPECTED_CHECKSUM   8'h14
`define ADDR_STATION_ADDRESS_LO  8'h18
`define ADDR_STATION_ADDRESS_HI  8'h1c
`define ADDR_CONTROLLER_STATUS   8'h20
`define ADDR_FRAME_RELEASE       8'h24

// Filter control fields
`define FC_GROUP_ADDRESS_EN      1
`define FC_OTHER_STATION_EN      2
`define FC_OWN_ADDRESS_EN        3
`define FC_SHORT_FRAME_REJ_EN    4
`define FC_FCS_CHECK_EN          6
`define FC_MODE_LSB              8
`define FC_MODE_MSB              11
`define FC_CHECKSUM_INVERT       12
`define FC_WAKE_PATTERN_EN       14
`define RX_FILTER_CONTROL_RESET  16'h0059

// Mac control fields
`define MC_PASS_EVERY_FRAME      1
`define MAC_CONTROL_ONE_RESET    16'h0000

// Checksum filter modes
`define MODE_OFF                 4'h0
`define MODE_CHECKSUM_ONLY       4'h1
`define MODE_CHECKSUM_BROADCAST  4'h2
`define MODE_CHECKSUM_HASH       4'h3

// Wake pattern shape
`define WAKE_SYNC_BYTES          3'h6
`define WAKE_REPEATS             4'hf
`define WAKE_SYNC_VALUE          8'hff

// Checksum window
`define WINDOW_BYTES             8'h40
`define PENDING_MAX              8'hff

`endif

// ### logic/byte_fifo2.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; in_ready comes from a flop so it can feed a top-level output.
module byte_fifo2 #(
	parameter WIDTH = 9
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             in_valid,
	output reg              in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:1];
	reg             rd_ptr;
	reg             wr_ptr;
	reg [1:0]       count;
	wire            push;
	wire            pop;
	wire [1:0]      next_count;

	assign push       = in_valid & in_ready;
	assign pop        = out_valid & out_ready;
	assign out_valid  = (count != 2'h0);
	assign out_data   = mem[rd_ptr];
	assign next_count = count + {1'b0, push} - {1'b0, pop};

	// Pointers, fill level and registered ready
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ptr   <= 1'b0;
			wr_ptr   <= 1'b0;
			count    <= 2'h0;
			in_ready <= 1'b1;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr      <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			count    <= next_count;
			in_ready <= (next_count != 2'h2); // Honest full, no overwrite
		end
	end

endmodule // byte_fifo2

// ### logic/wake_scanner.v
// Scans a byte stream for six all-ones bytes then the station address sixteen times.
// Assumes bytes arrive one per enabled cycle and frame_start clears it between frames.
`include "rx_pattern_filter_defines.vh"
module wake_scanner (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        frame_start,
	input  wire        byte_en,
	input  wire [7:0]  byte_in,
	input  wire [47:0] station_address,
	output reg         found
);

	reg [2:0] sync_cnt;
	reg [2:0] addr_pos;
	reg [3:0] repeat_cnt;
	wire [7:0] expect_byte;
	wire       addr_hit;

	assign expect_byte = station_address[{addr_pos, 3'b000} +: 8];
	assign addr_hit    = (byte_in == expect_byte);

	// Sync then address sequence; any other field is simply ignored
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_cnt   <= 3'h0;
			addr_pos   <= 3'h0;
			repeat_cnt <= 4'h0;
			found      <= 1'b0;
		end else if (frame_start) begin
			sync_cnt   <= 3'h0;
			addr_pos   <= 3'h0;
			repeat_cnt <= 4'h0;
			found      <= 1'b0;
		end else if (byte_en && !found) begin
			if (sync_cnt != `WAKE_SYNC_BYTES) begin
				if (byte_in == `WAKE_SYNC_VALUE) // RULE2
					sync_cnt <= sync_cnt + 3'h1;
				else
					sync_cnt <= 3'h0; // RULE17
			end else if (addr_hit) begin
				if (addr_pos == 3'h5) begin
					addr_pos <= 3'h0;
					if (repeat_cnt == `WAKE_REPEATS)
						found <= 1'b1; // RULE1
					else
						repeat_cnt <= repeat_cnt + 4'h1;
				end else begin
					addr_pos <= addr_pos + 3'h1;
				end
			end else if (addr_pos == 3'h0 && repeat_cnt == 4'h0 &&
					byte_in == `WAKE_SYNC_VALUE) begin
				sync_cnt <= sync_cnt; // Longer sync run, last six count
			end else begin
				// Restart; an all-ones byte may open a new sync run
				sync_cnt   <= (byte_in == `WAKE_SYNC_VALUE) ? 3'h1 : 3'h0; // RULE17
				addr_pos   <= 3'h0;
				repeat_cnt <= 4'h0;
			end
		end
	end

endmodule // wake_scanner

// ### logic/rx_pattern_filter.v
// Lowest-priority receive filters (wake pattern, masked checksum) and final decision.
// Assumes the MAC streams bytes with a last flag and gives the upper filter results
// and buffer free space before the last byte is taken.
// Registers are reached over APB with byte addresses.
// The verdict lands one cycle after the last byte leaves the buffer.
//
// Overview of operation
// RULE1 - Scan whole frame for wake pattern, accept
// RULE2 - Six all-ones bytes, then address sixteen times
// RULE3 - Ones-complement checksum over window, compare expected
// RULE4 - Invert flag selects equal or differing checksum
// RULE5 - Mode field ANDs checksum with other criteria
// RULE6 - Window offset counts from first destination byte
// RULE7 - Software uses offset zero or two-63
// RULE8 - Short frame missing window never matches
// RULE9 - Mask bit includes byte; cleared bytes omitted
// RULE10 - Checksum filter off at reset; failure discards
// RULE11 - Discard on buffer overflow or counter overflow
// RULE12 - Promiscuous enables accept every valid frame
// RULE13 - Pass-every bit also accepts errored frames
// RULE14 - Wake filter off at reset, own enable
// RULE15 - Station address registers supply local address
// RULE16 - Other fields ignored while scanning pattern
// RULE17 - Mismatch restarts sync detection
// RULE18 - Decision final before committing to buffer
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`include "rx_pattern_filter_defines.vh"
module rx_pattern_filter (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        rx_valid,
	output wire        rx_ready,
	input  wire [7:0]  rx_data,
	input  wire        rx_last,
	input  wire        crc_bad,
	input  wire        short_frame,
	input  wire        higher_accept,
	input  wire        broadcast_frame,
	input  wire        hash_hit,
	input  wire [15:0] buffer_free,
	output reg         frame_commit,
	output reg         frame_discard,
	output reg  [15:0] frame_length
);

	////////////////////////////////////////////////////////////////////////////
	// Registers and state
	// Configuration comes up with the checksum filter and the wake scanner off;
	// the status word packs pending frames in bits 7:0 and the last verdict in bit 8.

	reg  [15:0] rx_filter_control;
	reg  [15:0] mac_control_one;
	reg  [5:0]  window_offset;
	reg  [63:0] window_byte_mask;
	reg  [15:0] expected_checksum;
	reg  [47:0] station_address;
	reg  [7:0]  pending_frame_count;
	reg         last_accept;
	reg  [7:0]  byte_pos;
	reg  [15:0] byte_count;
	reg  [16:0] sum;
	reg         high_half;
	reg         window_full;
	reg         frame_start;
	reg         deciding;
	reg  [31:0] next_prdata;
	reg         next_pslverr;

	// Byte stream, bus strobes and the combinational decision terms
	wire        fifo_valid;
	wire [8:0]  fifo_data;
	wire        take;
	wire        wake_found;
	wire        bus_write;
	wire        release_frame;
	wire [7:0]  win_index;
	wire        in_window;
	wire        include_byte;
	wire [15:0] addend;
	wire [16:0] raw_sum;
	wire [16:0] folded;
	wire [15:0] final_checksum;
	wire        checksum_hit;
	wire        checksum_pass;
	wire        promiscuous;
	wire        reject_upper;
	wire        no_room;
	wire        accept;
	wire [3:0]  mode;

	////////////////////////////////////////////////////////////////////////////
	// Input buffer and byte stream; draining stalls for one decision cycle
	// The two-entry buffer soaks up the byte that arrives while draining stalls,
	// so a frame that follows at once loses nothing.

	byte_fifo2 #(.WIDTH(9)) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   ({rx_last, rx_data}),
		.out_valid (fifo_valid),
		.out_ready (!deciding),
		.out_data  (fifo_data)
	);

	// A byte moves on only when the decision cycle is not holding the drain
	assign take = fifo_valid & ~deciding;

	// Scanner only advances on bytes taken while its enable bit is set
	wake_scanner u_wake (
		.pclk            (pclk),
		.presetn         (presetn),
		.frame_start     (frame_start),
		.byte_en         (take & rx_filter_control[`FC_WAKE_PATTERN_EN]), // RULE14
		.byte_in         (fifo_data[7:0]), // RULE16
		.station_address (station_address), // RULE15
		.found           (wake_found)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB slave: ready one cycle after setup, read data prepared in setup
	// Exactly one access cycle per transfer, never a wait state.
	// Unmapped addresses answer with pslverr and write nothing;
	// the release word always reads as zero.

	// Writes land on the access edge, when the handshake completes
	assign bus_write     = psel & penable & pready & pwrite;
	assign release_frame = bus_write & (paddr == `ADDR_FRAME_RELEASE) & pwdata[0];

	// Read mux and unmapped detection
	// Built from paddr alone; the write chain below mirrors the same map
	always @* begin
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (paddr == `ADDR_RX_FILTER_CONTROL)
			next_prdata = {16'h0000, rx_filter_control};
		else if (paddr == `ADDR_MAC_CONTROL_ONE)
			next_prdata = {16'h0000, mac_control_one};
		else if (paddr == `ADDR_WINDOW_OFFSET)
			next_prdata = {26'h0000000, window_offset};
		else if (paddr == `ADDR_WINDOW_MASK_LO)
			next_prdata = window_byte_mask[31:0];
		else if (paddr == `ADDR_WINDOW_MASK_HI)
			next_prdata = window_byte_mask[63:32];
		else if (paddr == `ADDR_EXPECTED_CHECKSUM)
			next_prdata = {16'h0000, expected_checksum};
		else if (paddr == `ADDR_STATION_ADDRESS_LO)
			next_prdata = station_address[31:0];
		else if (paddr == `ADDR_STATION_ADDRESS_HI)
			next_prdata = {16'h0000, station_address[47:32]};
		else if (paddr == `ADDR_CONTROLLER_STATUS)
			next_prdata = {23'h000000, last_accept, pending_frame_count};
		else if (paddr == `ADDR_FRAME_RELEASE)
			next_prdata = 32'h0000_0000;
		else
			next_pslverr = 1'b1;
	end

	// Bus handshake and register writes
	// prdata and pslverr load only in the setup cycle and clear otherwise
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready            <= 1'b0;
			prdata            <= 32'h0000_0000;
			pslverr           <= 1'b0;
			rx_filter_control <= `RX_FILTER_CONTROL_RESET; // RULE10 RULE14
			mac_control_one   <= `MAC_CONTROL_ONE_RESET;
			window_offset     <= 6'h00;
			window_byte_mask  <= 64'h0;
			expected_checksum <= 16'h0000;
			station_address   <= 48'h0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0000_0000;
			pslverr <= psel & ~penable & next_pslverr;
			if (bus_write) begin
				if (paddr == `ADDR_RX_FILTER_CONTROL)
					rx_filter_control <= pwdata[15:0];
				else if (paddr == `ADDR_MAC_CONTROL_ONE)
					mac_control_one <= pwdata[15:0];
				else if (paddr == `ADDR_WINDOW_OFFSET)
					window_offset <= pwdata[5:0]; // RULE7
				else if (paddr == `ADDR_WINDOW_MASK_LO)
					window_byte_mask[31:0] <= pwdata;
				else if (paddr == `ADDR_WINDOW_MASK_HI)
					window_byte_mask[63:32] <= pwdata;
				else if (paddr == `ADDR_EXPECTED_CHECKSUM)
					expected_checksum <= pwdata[15:0];
				else if (paddr == `ADDR_STATION_ADDRESS_LO)
					station_address[31:0] <= pwdata;
				else if (paddr == `ADDR_STATION_ADDRESS_HI)
					station_address[47:32] <= pwdata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checksum window; bytes pair high then low in order of inclusion
	// Only included bytes flip the pairing, so a masked-out byte vanishes
	// instead of counting as zero; an odd last byte sits in the high half.
	// Offset one is not refused here: keeping clear of it is a software duty.

	assign win_index    = byte_pos - {2'b00, window_offset}; // RULE6
	assign in_window    = (byte_pos >= {2'b00, window_offset}) && (win_index < `WINDOW_BYTES);
	assign include_byte = in_window & window_byte_mask[win_index[5:0]]; // RULE9
	assign addend       = high_half ? {fifo_data[7:0], 8'h00} : {8'h00, fifo_data[7:0]};
	assign raw_sum      = {1'b0, sum[15:0]} + {1'b0, addend};
	// End-around carry keeps the sum in ones-complement form
	// A second carry cannot occur, so one fold is enough
	assign folded       = {1'b0, raw_sum[15:0]} + {16'h0000, raw_sum[16]};
	assign final_checksum = ~sum[15:0]; // RULE3

	// Per-frame position, length and running sum
	// byte_pos saturates, so very long frames cannot reopen the window
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_pos    <= 8'h00;
			byte_count  <= 16'h0000;
			sum         <= 17'h00000;
			high_half   <= 1'b1;
			window_full <= 1'b0;
		end else if (frame_start) begin
			byte_pos    <= 8'h00;
			byte_count  <= 16'h0000;
			sum         <= 17'h00000;
			high_half   <= 1'b1;
			window_full <= 1'b0;
		end else if (take) begin
			byte_count <= byte_count + 16'h0001;
			if (byte_pos != 8'hff)
				byte_pos <= byte_pos + 8'h01;
			if (include_byte) begin
				sum       <= folded; // RULE3 RULE9
				high_half <= ~high_half;
			end
			if (in_window && win_index == `WINDOW_BYTES - 8'h01)
				window_full <= 1'b1; // RULE8
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Final decision, one cycle after the last byte, before any commit
	// Room in the buffer and in the pending counter is required whatever the
	// other filters say; their levels and buffer_free must hold steady from
	// the last byte until the pulse.

	// Mode codes beyond the three decoded ones behave as off
	assign mode          = rx_filter_control[`FC_MODE_MSB:`FC_MODE_LSB];
	assign checksum_hit  = window_full & ((final_checksum == expected_checksum) ^
			rx_filter_control[`FC_CHECKSUM_INVERT]); // RULE4 RULE8
	assign checksum_pass = (mode == `MODE_CHECKSUM_ONLY) ? checksum_hit : // RULE5
			(mode == `MODE_CHECKSUM_BROADCAST) ? (checksum_hit & broadcast_frame) :
			(mode == `MODE_CHECKSUM_HASH) ? (checksum_hit & hash_hit) :
			1'b0; // RULE10
	// Promiscuous needs all three address enables together
	assign promiscuous   = rx_filter_control[`FC_OWN_ADDRESS_EN] &
			rx_filter_control[`FC_OTHER_STATION_EN] &
			rx_filter_control[`FC_GROUP_ADDRESS_EN]; // RULE12 RULE13
	// Error rejection is bypassed when every frame is to be passed
	assign reject_upper  = ~mac_control_one[`MC_PASS_EVERY_FRAME] & // RULE13
			((rx_filter_control[`FC_FCS_CHECK_EN] & crc_bad) |
			(rx_filter_control[`FC_SHORT_FRAME_REJ_EN] & short_frame)); // RULE12
	// Buffer space is weighed against the whole frame
	assign no_room       = (byte_count > buffer_free) ||
			(pending_frame_count == `PENDING_MAX); // RULE11
	assign accept        = ~no_room & ~reject_upper &
			(promiscuous | higher_accept | wake_found | checksum_pass); // RULE1 RULE10

	// Decision pulses and pending-frame counter
	// Commit and discard are exclusive one-cycle pulses
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deciding            <= 1'b0;
			frame_start         <= 1'b0;
			frame_commit        <= 1'b0;
			frame_discard       <= 1'b0;
			frame_length        <= 16'h0000;
			last_accept         <= 1'b0;
			pending_frame_count <= 8'h00;
		end else begin
			deciding      <= take & fifo_data[8];
			// Per-frame clears run during the stalled decision cycle, after the
			// verdict is sampled; a later clear would swallow the first byte of
			// a frame that follows at once
			frame_start   <= take & fifo_data[8];
			frame_commit  <= deciding & accept; // RULE18
			frame_discard <= deciding & ~accept; // RULE18
			if (deciding) begin
				frame_length <= byte_count;
				last_accept  <= accept;
			end
			// Commit and release in one cycle leave the count unchanged
			// A release at zero is ignored rather than wrapping the count
			if (deciding && accept && !release_frame)
				pending_frame_count <= pending_frame_count + 8'h01; // RULE11 RULE18
			else if (!(deciding && accept) && release_frame &&
					pending_frame_count != 8'h00)
				pending_frame_count <= pending_frame_count - 8'h01;
		end
	end

endmodule // rx_pattern_filter

// ### tb/rx_pattern_filter_checker.sv
// Port checker for the receive pattern filter.
// Assumes one clock pclk and active-low presetn; bound to the design below.
module rx_pattern_filter_checker (
	input logic		pclk,
	input logic		presetn,
	input logic		psel,
	input logic		penable,
	input logic		pwrite,
	input logic [7:0]	paddr,
	input logic [31:0]	pwdata,
	input logic [31:0]	prdata,
	input logic		pready,
	input logic		pslverr,
	input logic		rx_valid,
	input logic		rx_ready,
	input logic [7:0]	rx_data,
	input logic		rx_last,
	input logic		crc_bad,
	input logic		short_frame,
	input logic		higher_accept,
	input logic		broadcast_frame,
	input logic		hash_hit,
	input logic [15:0]	buffer_free,
	input logic		frame_commit,
	input logic		frame_discard,
	input logic [15:0]	frame_length
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answer shape
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_single: assert property (pready |=> !pready) else $error("pready too long");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("prdata not quiet");
	// Decision pulses, timing and room
	a_commit_pulse: assert property (frame_commit |=> !frame_commit)
		else $error("commit pulse too long");
	a_discard_pulse: assert property (frame_discard |=> !frame_discard)
		else $error("discard pulse too long");
	a_decision_alone: assert property (!(frame_commit && frame_discard))
		else $error("commit and discard together");
	a_decide_bound: assert property (rx_valid && rx_ready && rx_last |->
		##[2:8] (frame_commit || frame_discard)) else $error("no decision after last byte");
	a_room_kept: assert property (frame_commit |-> frame_length <= buffer_free)
		else $error("commit without room");
	a_length_with_pulse: assert property ($changed(frame_length) |->
		##[0:1] (frame_commit || frame_discard)) else $error("length moved without decision");
	cover property (frame_commit);
	cover property (frame_discard);
	cover property (pslverr);
endmodule // rx_pattern_filter_checker
////////////////////////////////////////////////////////////////
bind rx_pattern_filter rx_pattern_filter_checker i_rx_pattern_filter_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
	.crc_bad(crc_bad), .short_frame(short_frame), .higher_accept(higher_accept),
	.broadcast_frame(broadcast_frame), .hash_hit(hash_hit), .buffer_free(buffer_free),
	.frame_commit(frame_commit), .frame_discard(frame_discard), .frame_length(frame_length)
);

// ### tb/mac_rx_source.sv
// Byte source standing in for the MAC receive path.
// Assumes the bench fills fb and calls send; a byte moves on valid and ready.
module mac_rx_source (
	input logic		pclk,
	input logic		rx_ready,
	output logic		rx_valid,
	output logic [7:0]	rx_data,
	output logic		rx_last
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]	fb [0:255];
	logic		slow = 1'b0;
	// Idle lines at time zero
	initial begin
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_data = 8'h00;
	end
	// One frame; each byte held until taken, a gap before every byte but the first when slow
	task automatic send(input int n);
		@(posedge pclk);
		for (int k = 0; k < n; k++) begin
			if (slow && k > 0) begin
				rx_valid <= 1'b0;
				rx_data <= ~fb[k-1];
				@(posedge pclk);
			end
			rx_valid <= 1'b1;
			rx_data <= fb[k];
			rx_last <= (k == n - 1);
			do @(posedge pclk); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		// Released data shows the inverse, never a stale byte
		rx_data <= ~fb[n-1];
	endtask
endmodule // mac_rx_source

// ### tb/rx_pattern_filter_tb.sv
// Self-checking bench for the receive pattern filter.
// Assumes design, checker and byte source are compiled ahead of it.
`include "rx_pattern_filter_defines.vh"
module rx_pattern_filter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic		pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic		rx_valid, rx_ready, rx_last, crc_bad, short_frame, higher_accept;
	logic		broadcast_frame, hash_hit, frame_commit, frame_discard, got_commit;
	logic [7:0]	paddr, rx_data;
	logic [31:0]	pwdata, prdata, rd;
	logic [15:0]	buffer_free, frame_length, got_len;
	logic [48:0]	ck [0:6];
	int		errors, samples_checked, pulses, cyc, pend, p0;
	localparam logic [47:0] sta = 48'h020a0b0c0d0e;
	localparam logic [47:0] src = 48'h0004a3ffffff;
	rx_pattern_filter i_rx_pattern_filter (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
		.crc_bad(crc_bad), .short_frame(short_frame), .higher_accept(higher_accept),
		.broadcast_frame(broadcast_frame), .hash_hit(hash_hit), .buffer_free(buffer_free),
		.frame_commit(frame_commit), .frame_discard(frame_discard), .frame_length(frame_length));
	mac_rx_source i_mac_rx_source (.pclk(pclk), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last));
	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Decision capture and hang limit
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (frame_commit === 1'b1 || frame_discard === 1'b1) begin
			pulses <= pulses + 1;
			got_commit <= frame_commit;
			got_len <= frame_length;
		end
		if (cyc == 40000) begin
			errors++;
			final_report;
		end
	end
	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Bus transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Filler bytes, with a source address at bytes 6 to 11
	task automatic fill(input int n);
		for (int k = 0; k < n; k++)
			i_mac_rx_source.fb[k] = (k > 5 && k < 12) ? src[95-8*k -: 8] : k[7:0] ^ 8'h5a;
	endtask
	// Partial sync, full sync, sixteen address copies; bad spoils one copy
	task automatic wake(input logic bad);
		fill(110);
		for (int k = 0; k < 106; k++)
			i_mac_rx_source.fb[k+2] = (k == 3) ? 8'h00 : (k < 10) ? 8'hff :
				sta[47-8*((k-10)%6) -: 8];
		if (bad)
			i_mac_rx_source.fb[60] = 8'h00;
	endtask
	// Decision bounded so a silent design cannot pass on stale capture
	task automatic frame(input int n, input logic exp);
		int p;
		p = pulses;
		i_mac_rx_source.send(n);
		for (int t = 0; t < 12 && pulses == p; t++) @(posedge pclk);
		check("decided", pulses != p, 1'b1);
		check("commit", got_commit, exp);
		check("length", got_len, n);
		if (exp)
			pend++;
	endtask
	task automatic ck_run(input int i, input logic inv);
		apb(1, `ADDR_WINDOW_OFFSET, ck[i][48:41]);
		apb(1, `ADDR_WINDOW_MASK_LO, ck[i][40:25]);
		apb(1, `ADDR_EXPECTED_CHECKSUM, ck[i][24:9]);
		fill(ck[i][8:1]);
		frame(ck[i][8:1], ck[i][0] ^ inv);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{crc_bad, short_frame, higher_accept, broadcast_frame, hash_hit} = '0;
		buffer_free = 16'hffff;
		ck[0] = {8'd0, 16'h0fc0, 16'h5bfc, 8'd64, 1'b1};
		ck[1] = {8'd0, 16'h0ec0, 16'h00fb, 8'd64, 1'b1};
		ck[2] = {8'd0, 16'h0000, 16'hffff, 8'd63, 1'b0};
		ck[3] = {8'd0, 16'h0000, 16'hffff, 8'd64, 1'b1};
		ck[4] = {8'd6, 16'h0000, 16'hffff, 8'd69, 1'b0};
		ck[5] = {8'd6, 16'h0000, 16'hffff, 8'd70, 1'b1};
		ck[6] = {8'd0, 16'h0fc0, 16'h1234, 8'd64, 1'b0};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `ADDR_RX_FILTER_CONTROL, 0);
		check("control", rd, `RX_FILTER_CONTROL_RESET);
		apb(0, 8'h28, 0);
		check("slverr", err, 1'b1);
		check("err data", rd, 0);
		fill(64);
		frame(64, 0);
		higher_accept <= 1'b1;
		frame(64, 1);
		higher_accept <= 1'b0;
		apb(1, `ADDR_STATION_ADDRESS_LO, 32'h0c0b0a02);
		apb(1, `ADDR_STATION_ADDRESS_HI, 32'h00000e0d);
		apb(1, `ADDR_RX_FILTER_CONTROL, 32'h4000);
		i_mac_rx_source.slow = 1'b1;
		wake(0);
		frame(110, 1);
		i_mac_rx_source.slow = 1'b0;
		wake(1);
		frame(110, 0);
		apb(1, `ADDR_RX_FILTER_CONTROL, 0);
		wake(0);
		frame(110, 0);
		apb(1, `ADDR_WINDOW_MASK_HI, 0);
		apb(1, `ADDR_RX_FILTER_CONTROL, 32'h0100);
		for (int i = 0; i < 7; i++)
			ck_run(i, 0);
		apb(1, `ADDR_RX_FILTER_CONTROL, 32'h1100);
		ck_run(0, 1);
		ck_run(6, 1);
		ck_run(3, 1);
		// Every mode, each extra condition both ways
		for (int m = 0; m < 5; m++)
			for (int x = 0; x < 2; x++) begin
				broadcast_frame <= x[0];
				hash_hit <= ~x[0];
				apb(1, `ADDR_RX_FILTER_CONTROL, m << 8);
				frame(64, m == 1 || (m == 2 && x == 1) || (m == 3 && x == 0));
			end
		{broadcast_frame, hash_hit} <= 2'b00;
		apb(1, `ADDR_RX_FILTER_CONTROL, 32'h005e);
		frame(64, 1);
		crc_bad <= 1'b1;
		frame(64, 0);
		short_frame <= 1'b1;
		apb(1, `ADDR_MAC_CONTROL_ONE, 32'h2);
		frame(64, 1);
		{crc_bad, short_frame} <= 2'b00;
		buffer_free <= 16'd63;
		frame(64, 0);
		buffer_free <= 16'd64;
		frame(64, 1);
		buffer_free <= 16'hffff;
		// Back-to-back frames; the second keeps its first byte
		p0 = pulses;
		i_mac_rx_source.send(8);
		i_mac_rx_source.send(8);
		repeat (12) @(posedge pclk);
		check("b2b pulses", pulses - p0, 2);
		check("b2b commit", got_commit, 1'b1);
		check("b2b length", got_len, 8);
		pend += 2;
		apb(0, `ADDR_CONTROLLER_STATUS, 0);
		check("pending", rd[7:0], pend);
		while (pend < 255)
			frame(8, 1);
		frame(8, 0);
		apb(1, `ADDR_FRAME_RELEASE, 1);
		apb(0, `ADDR_CONTROLLER_STATUS, 0);
		check("pending", rd[7:0], 32'd254);
		final_report;
	end
endmodule // rx_pattern_filter_tb
